// >>> hw/hdti_pkg.sv
package hdti_pkg;
    localparam int              ADDR_W       = 10;
    localparam int              DATA_W       = 8;
    localparam int              EN_W         = 4;
    localparam logic [ADDR_W-1:0] OFS_TRIGGER = 10'h012;
    localparam logic [ADDR_W-1:0] OFS_IRQCTL  = 10'h013;
    localparam logic [DATA_W-1:0] TRIG_TO_CARD = 8'h00;
    localparam logic [DATA_W-1:0] TRIG_TO_HOST = 8'h01;
    localparam logic [EN_W-1:0]   EN_RESET     = 4'h0;
    localparam int              EN_DMA_END   = 0;
    localparam int              EN_ERROR     = 1;
    localparam int              EN_OUT_RDY   = 2;
    localparam int              EN_IN_RDY    = 3;
    localparam logic            DIR_TO_CARD  = 1'b0;
    localparam logic            DIR_TO_HOST  = 1'b1;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_WAIT  = 4'h2,
        ST_REQ   = 4'h4,
        ST_DRAIN = 4'h8
    } hdti_dma_state_t;
endpackage

// >>> hw/hdti_dma_seq.sv
`timescale 1ns/100ps
module hdti_dma_seq (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start,
    input  wire logic start_dir,
    input  wire logic link_input_ready_flag,
    input  wire logic link_output_ready_flag,
    input  wire logic dma_ack,
    input  wire logic dma_tc,
    output logic      dreq_q,
    output logic      dir_q,
    output logic      busy_q,
    output logic      done_q
);
    hdti_pkg::hdti_dma_state_t st_q;
    hdti_pkg::hdti_dma_state_t st_d;
    logic                      dreq_d;
    logic                      dir_d;
    logic                      busy_d;
    logic                      done_d;
    logic                      rdy;

    // to card needs room in the adapter, to host needs a byte waiting
    assign rdy = (dir_q == hdti_pkg::DIR_TO_HOST) ? link_input_ready_flag : link_output_ready_flag;

    always_comb begin
        st_d   = st_q;
        dir_d  = dir_q;
        dreq_d = 1'b0;
        done_d = 1'b0;
        case (st_q)
            hdti_pkg::ST_IDLE: begin
                if (start) begin
                    dir_d = start_dir;
                    st_d  = hdti_pkg::ST_WAIT;
                end
            end
            hdti_pkg::ST_WAIT: begin
                if (rdy) begin
                    dreq_d = 1'b1;
                    st_d   = hdti_pkg::ST_REQ;
                end
            end
            hdti_pkg::ST_REQ: begin
                dreq_d = 1'b1;
                if (dma_ack) begin
                    dreq_d = 1'b0;
                    if (dma_tc) begin
                        done_d = 1'b1;
                        st_d   = hdti_pkg::ST_IDLE;
                    end else begin
                        st_d = hdti_pkg::ST_DRAIN;
                    end
                end
            end
            hdti_pkg::ST_DRAIN: begin
                // flag lags the byte; waiting for it to fall avoids a double request
                if (!rdy) begin
                    st_d = hdti_pkg::ST_WAIT;
                end
            end
            default: begin
                st_d = hdti_pkg::ST_IDLE;
            end
        endcase
        busy_d = (st_d != hdti_pkg::ST_IDLE);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= hdti_pkg::ST_IDLE;
            dir_q  <= hdti_pkg::DIR_TO_CARD;
            dreq_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            dir_q  <= dir_d;
            dreq_q <= dreq_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_byte_taken;
        dreq_q && dma_ack;
    endsequence

    sequence s_last_byte;
        dreq_q && dma_ack && dma_tc;
    endsequence

    chk_req_after_ready: assert property ($rose(dreq_q) |-> $past(rdy))
        else $error("request raised without adapter ready");
    chk_req_held_wait: assert property (dreq_q && !dma_ack |=> dreq_q)
        else $error("request dropped before acknowledge");
    chk_one_byte_req: assert property (s_byte_taken |=> !dreq_q ##1 !dreq_q)
        else $error("request not dropped after one byte");
    chk_done_on_tc: assert property (s_last_byte |=> done_q && !busy_q)
        else $error("terminal count did not end transfer");
    chk_start_dir_kept: assert property (start && !busy_q |=> busy_q && dir_q == $past(start_dir))
        else $error("trigger did not start in given direction");
endmodule

// >>> hw/hdti_card.sv
`timescale 1ns/100ps
// Overview of operation
// - writing 0 to trigger port moves host to card, 1 card to host
// - trigger port decodes at base plus 0x12
// - one DMA request per byte, dropped after each acknowledge
// - interrupt control at base plus 0x13, write only, low four bits used
// - enable bits: DMA end, error, output ready, input ready
// - 1 enables an event, 0 disables it, any combination allowed
// - all enabled events share one interrupt line
// - enables reset to 0 and line floats while all are 0
// - any enable set drives line low, enabled event drives it high
// - clearing bit 0 disables and drops pending DMA end
// - setting bit 0 again waits for a new DMA completion
// - ready events hold the line while their flag stands or until disabled
// - switch on routes to IRQ3, off routes to IRQ5
// - error and both ready flags are readable as status
module hdti_card #(
    parameter int ADDR_W = hdti_pkg::ADDR_W,
    parameter int DATA_W = hdti_pkg::DATA_W
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] base_addr,
    input  wire logic [ADDR_W-1:0] io_addr,
    input  wire logic              io_wr,
    input  wire logic [DATA_W-1:0] io_wdata,
    input  wire logic              dma_ack,
    input  wire logic              dma_tc,
    input  wire logic              card_error,
    input  wire logic              link_input_ready_flag,
    input  wire logic              link_output_ready_flag,
    input  wire logic              irq_sel_sw,
    output logic                   dma_req,
    output logic                   dma_dir,
    output logic                   dma_busy,
    output logic                   irq3_o,
    output logic                   irq3_oe,
    output logic                   irq5_o,
    output logic                   irq5_oe,
    output logic                   stat_error,
    output logic                   stat_in_rdy,
    output logic                   stat_out_rdy
);
    localparam int EN_W = hdti_pkg::EN_W;
    localparam logic [EN_W-1:0] EN_RESET = hdti_pkg::EN_RESET;

    logic [EN_W-1:0] en_q;
    logic [EN_W-1:0] en_d;
    logic [EN_W-1:0] ev_vec;
    logic            dma_end_q;
    logic            dma_end_d;
    logic            irq_lvl_d;
    logic            irq_drv_d;
    logic            irq_lvl_q;
    logic            irq_drv_q;
    logic            sel3_q;
    logic            irq3_o_d;
    logic            irq3_oe_d;
    logic            irq5_o_d;
    logic            irq5_oe_d;
    logic            stat_err_q;
    logic            stat_in_q;
    logic            stat_out_q;
    logic            wr_trig;
    logic            wr_ctl;
    logic            trig_ok;
    logic            dma_done;
    logic [ADDR_W-1:0] trig_addr;
    logic [ADDR_W-1:0] ctl_addr;

    assign trig_addr = ADDR_W'(base_addr + hdti_pkg::OFS_TRIGGER);
    assign ctl_addr  = ADDR_W'(base_addr + hdti_pkg::OFS_IRQCTL);
    assign wr_trig   = io_wr && (io_addr == trig_addr);
    assign wr_ctl    = io_wr && (io_addr == ctl_addr);
    // other data values and triggers during a running transfer are ignored
    assign trig_ok   = wr_trig && (io_wdata == hdti_pkg::TRIG_TO_CARD || io_wdata == hdti_pkg::TRIG_TO_HOST);

    hdti_dma_seq u_seq (
        .clk                    (clk),
        .rst_n                  (rst_n),
        .start                  (trig_ok),
        .start_dir              (io_wdata == hdti_pkg::TRIG_TO_HOST),
        .link_input_ready_flag  (link_input_ready_flag),
        .link_output_ready_flag (link_output_ready_flag),
        .dma_ack                (dma_ack),
        .dma_tc                 (dma_tc),
        .dreq_q                 (dma_req),
        .dir_q                  (dma_dir),
        .busy_q                 (dma_busy),
        .done_q                 (dma_done)
    );

    assign ev_vec = {link_input_ready_flag, link_output_ready_flag, card_error, dma_end_q};

    always_comb begin
        en_d = en_q;
        if (wr_ctl) begin
            en_d = io_wdata[EN_W-1:0];
        end
        // completion while bit 0 is off is dropped, so re-enabling cannot replay it
        if (dma_done && en_q[hdti_pkg::EN_DMA_END]) begin
            dma_end_d = 1'b1;
        end else if (!en_q[hdti_pkg::EN_DMA_END]) begin
            dma_end_d = 1'b0;
        end else begin
            dma_end_d = dma_end_q;
        end
        irq_lvl_d = |(en_q & ev_vec);
        irq_drv_d = |en_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q       <= hdti_pkg::EN_RESET;
            dma_end_q  <= 1'b0;
            irq_lvl_q  <= 1'b0;
            irq_drv_q  <= 1'b0;
            sel3_q     <= 1'b0;
            stat_err_q <= 1'b0;
            stat_in_q  <= 1'b0;
            stat_out_q <= 1'b0;
        end else begin
            en_q       <= en_d;
            dma_end_q  <= dma_end_d;
            irq_lvl_q  <= irq_lvl_d;
            irq_drv_q  <= irq_drv_d;
            sel3_q     <= irq_sel_sw;
            stat_err_q <= card_error;
            stat_in_q  <= link_input_ready_flag;
            stat_out_q <= link_output_ready_flag;
        end
    end

    // routing uses the switch of the previous cycle; the switch is static in use
    always_comb begin
        irq3_o_d  = irq_lvl_q && sel3_q;
        irq3_oe_d = irq_drv_q && sel3_q;
        irq5_o_d  = irq_lvl_q && !sel3_q;
        irq5_oe_d = irq_drv_q && !sel3_q;
    end

    // pins leave a flop so the host bus never sees a decode glitch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq3_o  <= 1'b0;
            irq3_oe <= 1'b0;
            irq5_o  <= 1'b0;
            irq5_oe <= 1'b0;
        end else begin
            irq3_o  <= irq3_o_d;
            irq3_oe <= irq3_oe_d;
            irq5_o  <= irq5_o_d;
            irq5_oe <= irq5_oe_d;
        end
    end

    assign stat_error   = stat_err_q;
    assign stat_in_rdy  = stat_in_q;
    assign stat_out_rdy = stat_out_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_ctl_write_low: assert property (wr_ctl |=> en_q == $past(io_wdata[EN_W-1:0]))
        else $error("control write not stored in low bits");
    chk_float_when_off: assert property (en_q == EN_RESET ##1 en_q == EN_RESET |=> !irq3_oe && !irq5_oe)
        else $error("line driven with all enables off");
    chk_drive_when_on: assert property (en_q != EN_RESET |=> ##1 (irq3_oe || irq5_oe))
        else $error("line not driven with an enable set");
    chk_one_line_only: assert property (!(irq3_oe && irq5_oe))
        else $error("both lines driven");
    chk_route_irq3: assert property (irq_drv_q && sel3_q |=> irq3_oe && !irq5_oe)
        else $error("switch on did not route to IRQ3");
    chk_dma_end_drop: assert property (!en_q[hdti_pkg::EN_DMA_END] |=> !dma_end_q)
        else $error("DMA end pending with bit 0 clear");
    chk_reenable_quiet: assert property ($rose(en_q[hdti_pkg::EN_DMA_END]) |-> !dma_end_q)
        else $error("re-enable replayed DMA end");
    chk_dma_end_set: assert property (dma_done && en_q[hdti_pkg::EN_DMA_END] |=> dma_end_q)
        else $error("completion not latched");
    chk_ready_irq_high: assert property (en_q[hdti_pkg::EN_IN_RDY] && link_input_ready_flag |=> irq_lvl_q)
        else $error("input ready did not hold interrupt");
    chk_status_copy: assert property (##1 stat_error == $past(card_error))
        else $error("error status not readable");

    // named sequences used by chk_enable_path and chk_start_decode, then further checks
    sequence s_enable_write;
        wr_ctl && (io_wdata[EN_W-1:0] != EN_RESET);
    endsequence

    sequence s_start_write;
        trig_ok && !dma_busy;
    endsequence

    // control write reaches the pins three edges later
    chk_enable_path: assert property (s_enable_write |-> ##3 (irq3_oe || irq5_oe))
        else $error("enable write did not drive the line");
    chk_en_stands: assert property (!wr_ctl |=> $stable(en_q))
        else $error("enables changed without a write");
    chk_start_decode: assert property (s_start_write |=> dma_busy)
        else $error("trigger write did not start a transfer");
    chk_trig_refused: assert property (wr_trig && !trig_ok && !dma_busy |=> !dma_busy)
        else $error("unknown trigger value started a transfer");
    chk_error_irq: assert property (en_q[hdti_pkg::EN_ERROR] && card_error |=> irq_lvl_q)
        else $error("enabled error did not raise interrupt");
    chk_out_rdy_irq: assert property (en_q[hdti_pkg::EN_OUT_RDY] && link_output_ready_flag |=> irq_lvl_q)
        else $error("enabled output ready did not raise interrupt");
    chk_dma_end_irq: assert property (en_q[hdti_pkg::EN_DMA_END] && dma_end_q |=> irq_lvl_q)
        else $error("pending DMA end did not raise interrupt");
    chk_quiet_no_event: assert property ((en_q & ev_vec) == EN_RESET |=> !irq_lvl_q)
        else $error("interrupt raised with no enabled event");
    chk_irq3_level: assert property (irq_lvl_q && sel3_q |=> irq3_o)
        else $error("line not driven high on event");
    chk_route_irq5: assert property (irq_drv_q && !sel3_q |=> irq5_oe && !irq3_oe)
        else $error("switch off did not route to IRQ5");
    chk_dma_end_hold: assert property (dma_end_q && en_q[hdti_pkg::EN_DMA_END] |=> dma_end_q)
        else $error("DMA end lost while bit 0 set");
    chk_in_status: assert property (##1 stat_in_rdy == $past(link_input_ready_flag))
        else $error("input ready status not readable");
    chk_out_status: assert property (##1 stat_out_rdy == $past(link_output_ready_flag))
        else $error("output ready status not readable");
endmodule

// >>> test/hdti_host_model.sv
`timescale 1ns/100ps
module hdti_host_model (
    input  wire logic       clk,
    input  wire logic       dma_req,
    input  wire logic [7:0] nbytes,
    input  wire logic [7:0] lat,
    output logic            dma_ack,
    output logic            dma_tc,
    output logic            rdy
);
    int n;
    initial begin
        dma_ack = 1'b0;
        dma_tc  = 1'b0;
        rdy     = 1'b1;
        n       = 0;
        forever begin
            @(negedge clk);
            if (dma_req) begin
                repeat (lat) @(negedge clk);
                n++;
                dma_ack = 1'b1;
                dma_tc  = (n == nbytes);
                @(negedge clk);
                dma_ack = 1'b0;
                dma_tc  = 1'b0;
                // adapter busy with the byte, so the flag drops
                rdy = 1'b0;
                repeat (2) @(negedge clk);
                rdy = 1'b1;
                if (n == nbytes) begin
                    n = 0;
                end
            end
        end
    end
endmodule

// >>> test/hdti_card_tb.sv
`timescale 1ns/100ps
module hdti_card_tb;
    localparam logic [9:0] BASE = 10'h150;
    logic       clk;
    logic       rst_n;
    logic [9:0] io_addr;
    logic       io_wr;
    logic [7:0] io_wdata;
    logic       card_error;
    logic       in_ev;
    logic       out_ev;
    logic       sw;
    logic [1:0] mode;
    logic [7:0] nbytes;
    logic [7:0] lat;
    logic       req_d;
    logic       dma_ack;
    logic       dma_tc;
    logic       rdy;
    logic       dma_req;
    logic       dma_dir;
    logic       dma_busy;
    logic       irq3_o;
    logic       irq3_oe;
    logic       irq5_o;
    logic       irq5_oe;
    logic       stat_error;
    logic       stat_in_rdy;
    logic       stat_out_rdy;
    logic       in_flag;
    logic       out_flag;
    int         reqs;
    int         mismatches;
    int         cmp_count;
    assign out_flag = (mode == 2'd1) ? rdy : out_ev;
    assign in_flag  = (mode == 2'd2) ? rdy : in_ev;
    hdti_card i_hdti_card (.clk(clk), .rst_n(rst_n), .base_addr(BASE), .io_addr(io_addr), .io_wr(io_wr),
        .io_wdata(io_wdata), .dma_ack(dma_ack), .dma_tc(dma_tc), .card_error(card_error),
        .link_input_ready_flag(in_flag), .link_output_ready_flag(out_flag), .irq_sel_sw(sw),
        .dma_req(dma_req), .dma_dir(dma_dir), .dma_busy(dma_busy), .irq3_o(irq3_o), .irq3_oe(irq3_oe),
        .irq5_o(irq5_o), .irq5_oe(irq5_oe), .stat_error(stat_error), .stat_in_rdy(stat_in_rdy),
        .stat_out_rdy(stat_out_rdy));
    hdti_host_model i_hdti_host_model (.clk(clk), .dma_req(dma_req), .nbytes(nbytes), .lat(lat),
        .dma_ack(dma_ack), .dma_tc(dma_tc), .rdy(rdy));
    always @(posedge clk) begin
        req_d <= dma_req;
        if (dma_req && !req_d) begin
            reqs <= reqs + 1;
        end
    end
    function automatic logic [7:0] pins;
        return {4'h0, irq3_oe, irq3_o, irq5_oe, irq5_o};
    endfunction
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [9:0] ofs, input logic [7:0] d);
        io_addr  = BASE + ofs;
        io_wdata = d;
        io_wr    = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task automatic ev(input logic [2:0] v);
        {in_ev, out_ev, card_error} = v;
        repeat (3) @(negedge clk);
        chk({5'h00, stat_in_rdy, stat_out_rdy, stat_error}, {5'h00, v});
    endtask
    task automatic t_enables;
        for (int i = 1; i < 4; i++) begin
            wr(hdti_pkg::OFS_IRQCTL, 8'hf0 | (8'h01 << i));
            chk(pins(), 8'h08);
            ev(3'b001 << (i - 1));
            chk(pins(), 8'h0c);
            wr(hdti_pkg::OFS_IRQCTL, 8'h01 << ((i % 3) + 1));
            chk(pins(), 8'h08);
            wr(hdti_pkg::OFS_IRQCTL, 8'h0e);
            chk(pins(), 8'h0c);
            ev(3'b000);
            chk(pins(), 8'h08);
        end
        wr(hdti_pkg::OFS_IRQCTL, 8'h00);
        chk(pins(), 8'h00);
    endtask
    task automatic t_decode;
        wr(hdti_pkg::OFS_IRQCTL + 10'h001, 8'h0f);
        chk(pins(), 8'h00);
        wr(hdti_pkg::OFS_TRIGGER, 8'h02);
        chk({7'h00, dma_busy}, 8'h00);
        sw = 1'b0;
        wr(hdti_pkg::OFS_IRQCTL, 8'h02);
        ev(3'b001);
        chk(pins(), 8'h03);
        ev(3'b000);
        wr(hdti_pkg::OFS_IRQCTL, 8'h00);
        sw = 1'b1;
    endtask
    task automatic t_dma(input logic [7:0] d, input logic [7:0] n, input logic [7:0] lt);
        int k;
        int r0;
        nbytes = n;
        lat    = lt;
        mode   = d[0] ? 2'd2 : 2'd1;
        r0     = reqs;
        wr(hdti_pkg::OFS_IRQCTL, 8'h01);
        wr(hdti_pkg::OFS_TRIGGER, d);
        chk({7'h00, dma_dir}, d);
        k = 0;
        while (dma_busy !== 1'b0 && k < 500) begin
            @(negedge clk);
            k++;
        end
        if (dma_busy !== 1'b0) begin
            mismatches++;
            close_out;
        end
        repeat (4) @(negedge clk);
        chk(8'(reqs - r0), n);
        chk(pins(), 8'h0c);
        mode = 2'd0;
    endtask
    task automatic t_reset;
        wr(hdti_pkg::OFS_IRQCTL, 8'h0f);
        chk(pins(), 8'h0c);
        rst_n = 1'b0;
        @(negedge clk);
        chk(pins(), 8'h00);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(pins(), 8'h00);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {rst_n, io_addr, io_wr, io_wdata, card_error, in_ev, out_ev, mode, lat} = '0;
        {sw, nbytes} = 9'h101;
        repeat (10) @(negedge clk);
        rst_n = 1'b1; // hardware reset precedes all traffic
        chk(pins(), 8'h00);
        t_enables();
        t_decode();
        t_dma(hdti_pkg::TRIG_TO_CARD, 8'h03, 8'h00);
        wr(hdti_pkg::OFS_IRQCTL, 8'h02);
        chk(pins(), 8'h08);
        wr(hdti_pkg::OFS_IRQCTL, 8'h01);
        chk(pins(), 8'h08);
        t_dma(hdti_pkg::TRIG_TO_HOST, 8'h02, 8'h05);
        t_reset();
        close_out();
    end
endmodule
